// *** core/ssst_fifo.sv ***
// ssst_fifo: small flip-flop fifo with valid/ready on both ends.
// assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ssst_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != FULL);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_nxt = mem_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wr_r] = in_data;
      wr_nxt = (wr_r == LAST) ? '0 : wr_r + 1'b1;
    end
    if (pop) begin
      rd_nxt = (rd_r == LAST) ? '0 : rd_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
    mem_r <= mem_nxt;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_fifo_no_overrun: assert property (cnt_r <= FULL) else $error("fifo count above depth");
endmodule : ssst_fifo

// *** core/ssst_pkg.sv ***
// ssst_pkg: constants shared by the sensor serial slave and its fifo.
// assumes a 100 MHz mclk; times are kept in their own units and converted here.
package ssst_pkg;
  localparam int unsigned MCLK_HZ = 100_000_000;
  localparam int unsigned NS_PER_CYC = 1_000_000_000 / MCLK_HZ;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned SETTING_W = 4;
  localparam logic [3:0] FAST_MIN_SETTING = 4'h7;
  // sleep recovery, 2.5 ms, a least time so rounded up
  localparam int unsigned WAKE_TIME_US = 2500;
  localparam int unsigned WAKE_CYC = (WAKE_TIME_US * 1000 + NS_PER_CYC - 1) / NS_PER_CYC;
  // shortest conversion period, 3.906 ms
  localparam int unsigned CONV_TIME_NS = 3_906_000;
  localparam int unsigned CONV_CYC = CONV_TIME_NS / NS_PER_CYC;
  localparam int unsigned MULT_W = 11;
  // conversion period in base periods, indexed by the sample period setting
  localparam logic [10:0] PERIOD_MULT [16] = '{
    11'h001, 11'h001, 11'h002, 11'h003, 11'h004, 11'h006, 11'h008, 11'h00c,
    11'h010, 11'h020, 11'h040, 11'h080, 11'h100, 11'h200, 11'h400, 11'h7c0};
  typedef enum logic [1:0] {
    SSST_ACTIVE = 2'b00,
    SSST_SLEEP = 2'b01,
    SSST_WAKE = 2'b11
  } ssst_pwr_type;
endpackage : ssst_pkg

// *** core/ssst_spi_dev.sv ***
// ssst_spi_dev: serial slave port of a rate sensor, with sleep wake and conversion pacing.
// assumes cs_n, sclk and din come straight from pins and are sampled by mclk (100 MHz),
// with sclk at least eight mclk periods per half cycle.
`timescale 1ns/1ps
module ssst_spi_dev #(
  parameter int unsigned WIDTH = ssst_pkg::WORD_W,
  parameter int unsigned DEPTH = ssst_pkg::FIFO_DEPTH,
  parameter int unsigned WAKE_CYC = ssst_pkg::WAKE_CYC,
  parameter int unsigned CONV_CYC = ssst_pkg::CONV_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout_o,
  output logic dout_oe,
  // words to send
  input wire logic [WIDTH-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // words received
  output logic [WIDTH-1:0] rx_data,
  output logic rx_valid,
  // control
  input wire logic [ssst_pkg::SETTING_W-1:0] sample_period_setting,
  input wire logic sleep_req,
  // status
  output logic fast_mode,
  output logic awake,
  output logic conv_strobe,
  output logic busy
);
  localparam int unsigned BW = $clog2(WIDTH);
  localparam logic [BW-1:0] LAST_BIT = BW'(WIDTH - 1);
  localparam logic [31:0] WAKE_LAST = 32'(WAKE_CYC - 1);
  localparam logic [31:0] CONV_LAST = 32'(CONV_CYC - 1);

  // pin synchronisers: s1 feeds only s2, s2 and d feed the edge detect
  logic [2:0] pin_s1_r, pin_s2_r, pin_d_r;
  logic cs_act, cs_fall, sclk_rise, sclk_fall, din_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_s1_r <= 3'h7;
      pin_s2_r <= 3'h7;
      pin_d_r <= 3'h7;
    end else begin
      pin_s1_r <= {cs_n, sclk, din};
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  assign cs_act = !pin_s2_r[2];
  assign cs_fall = pin_d_r[2] && !pin_s2_r[2];
  assign sclk_rise = !pin_d_r[1] && pin_s2_r[1];
  assign sclk_fall = pin_d_r[1] && !pin_s2_r[1];
  assign din_q = pin_s2_r[0];

  // outgoing words queue here; the port drains one per frame, so the queue fills
  logic f_valid, f_pop;
  logic [WIDTH-1:0] f_data;

  ssst_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_txq (
    .mclk(mclk),
    .rst(rst),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // serial shifter
  logic [WIDTH-1:0] shift_r, shift_nxt, rxsh_r, rxsh_nxt, rx_data_r, rx_data_nxt;
  logic [BW-1:0] bitcnt_r, bitcnt_nxt;
  logic skip_r, skip_nxt, dout_r, dout_nxt, oe_r, oe_nxt, rxv_r, rxv_nxt;

  always_comb begin
    shift_nxt = shift_r;
    rxsh_nxt = rxsh_r;
    rx_data_nxt = rx_data_r;
    bitcnt_nxt = bitcnt_r;
    skip_nxt = skip_r;
    dout_nxt = dout_r;
    rxv_nxt = 1'b0;
    f_pop = 1'b0;
    oe_nxt = cs_act;
    if (cs_fall) begin
      // an empty queue sends zeros rather than stalling the master
      shift_nxt = f_valid ? f_data : '0;
      f_pop = f_valid;
      dout_nxt = f_valid ? f_data[WIDTH-1] : 1'b0;
      bitcnt_nxt = '0;
      skip_nxt = 1'b1;
    end else if (cs_act) begin
      if (sclk_rise) begin
        rxsh_nxt = {rxsh_r[WIDTH-2:0], din_q};
        if (bitcnt_r == LAST_BIT) begin
          rx_data_nxt = {rxsh_r[WIDTH-2:0], din_q};
          rxv_nxt = 1'b1;
          bitcnt_nxt = '0;
        end else begin
          bitcnt_nxt = bitcnt_r + 1'b1;
        end
      end
      if (sclk_fall) begin
        // the first falling edge precedes the msb capture, so it launches nothing
        if (skip_r) begin
          skip_nxt = 1'b0;
        end else begin
          shift_nxt = {shift_r[WIDTH-2:0], 1'b0};
          dout_nxt = shift_r[WIDTH-2];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      shift_r <= '0;
      rxsh_r <= '0;
      rx_data_r <= '0;
      bitcnt_r <= '0;
      skip_r <= 1'b0;
      dout_r <= 1'b0;
      oe_r <= 1'b0;
      rxv_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      rxsh_r <= rxsh_nxt;
      rx_data_r <= rx_data_nxt;
      bitcnt_r <= bitcnt_nxt;
      skip_r <= skip_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      rxv_r <= rxv_nxt;
    end
  end

  assign dout_o = dout_r;
  assign dout_oe = oe_r;
  assign rx_data = rx_data_r;
  assign rx_valid = rxv_r;
  assign busy = oe_r;

  // power state
  ssst_pkg::ssst_pwr_type pwr_r, pwr_nxt;
  logic [31:0] wake_cnt_r, wake_cnt_nxt;

  always_comb begin
    pwr_nxt = pwr_r;
    wake_cnt_nxt = wake_cnt_r;
    case (pwr_r)
      ssst_pkg::SSST_ACTIVE: begin
        if (sleep_req) begin
          pwr_nxt = ssst_pkg::SSST_SLEEP;
        end
      end
      ssst_pkg::SSST_SLEEP: begin
        if (cs_fall) begin
          pwr_nxt = ssst_pkg::SSST_WAKE;
          wake_cnt_nxt = WAKE_LAST;
        end
      end
      ssst_pkg::SSST_WAKE: begin
        if (wake_cnt_r == '0) begin
          pwr_nxt = ssst_pkg::SSST_ACTIVE;
        end else begin
          wake_cnt_nxt = wake_cnt_r - 1'b1;
        end
      end
      default: begin
        pwr_nxt = ssst_pkg::SSST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pwr_r <= ssst_pkg::SSST_ACTIVE;
      wake_cnt_r <= '0;
    end else begin
      pwr_r <= pwr_nxt;
      wake_cnt_r <= wake_cnt_nxt;
    end
  end

  assign awake = (pwr_r == ssst_pkg::SSST_ACTIVE);
  assign fast_mode = (sample_period_setting >= ssst_pkg::FAST_MIN_SETTING);

  // conversion pacing: base period times a per-setting multiple
  logic [31:0] base_r, base_nxt;
  logic [ssst_pkg::MULT_W-1:0] mult_r, mult_nxt, mult_last;
  logic conv_r, conv_nxt;

  assign mult_last = ssst_pkg::PERIOD_MULT[sample_period_setting] - 1'b1;

  always_comb begin
    base_nxt = base_r;
    mult_nxt = mult_r;
    conv_nxt = 1'b0;
    if (!awake) begin
      // nothing converts while asleep or recovering
      base_nxt = '0;
      mult_nxt = '0;
    end else if (base_r == CONV_LAST) begin
      base_nxt = '0;
      if (mult_r >= mult_last) begin
        mult_nxt = '0;
        conv_nxt = 1'b1;
      end else begin
        mult_nxt = mult_r + 1'b1;
      end
    end else begin
      base_nxt = base_r + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      base_r <= '0;
      mult_r <= '0;
      conv_r <= 1'b0;
    end else begin
      base_r <= base_nxt;
      mult_r <= mult_nxt;
      conv_r <= conv_nxt;
    end
  end

  assign conv_strobe = conv_r;

  // pacing check: cycles since the last strobe, and whether power and setting held meanwhile
  logic [31:0] gap_r, gap_nxt, conv_period;
  logic [ssst_pkg::SETTING_W-1:0] set_d_r, set_d_nxt;
  logic steady_r, steady_nxt;

  assign conv_period = 32'(CONV_CYC * ssst_pkg::PERIOD_MULT[sample_period_setting]);

  always_comb begin
    gap_nxt = gap_r + 1'b1;
    set_d_nxt = sample_period_setting;
    // a setting change or a nap makes the next gap meaningless, so it is not judged
    steady_nxt = steady_r && awake && (sample_period_setting == set_d_r);
    if (conv_strobe) begin
      gap_nxt = '0;
      steady_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      gap_r <= '0;
      set_d_r <= '0;
      steady_r <= 1'b0;
    end else begin
      gap_r <= gap_nxt;
      set_d_r <= set_d_nxt;
      steady_r <= steady_nxt;
    end
  end

  // checks
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (rst);

  a_msb_on_select: assert property (cs_fall && f_valid
    |=> dout_oe && dout_o == $past(f_data[WIDTH-1]))
    else $error("msb not driven at select");
  a_shift_on_fall: assert property (cs_act && !cs_fall && sclk_fall && !skip_r
    |=> dout_o == $past(shift_r[WIDTH-2]))
    else $error("bit not launched after falling sclk");
  a_first_fall_holds: assert property (cs_act && !cs_fall && sclk_fall && skip_r
    |=> $stable(dout_o))
    else $error("first falling edge moved dout");
  a_word_capture: assert property (cs_act && !cs_fall && sclk_rise && bitcnt_r == LAST_BIT
    |=> rx_valid && rx_data[0] == $past(din_q))
    else $error("word not delivered on last rising edge");
  a_release_dout: assert property (!cs_act |=> !dout_oe)
    else $error("dout driven while deselected");
  a_idle_ignored: assert property (!cs_act |=> $stable(bitcnt_r) && !rx_valid)
    else $error("deselected activity changed the shifter");
  a_count_restart: assert property (cs_fall |=> bitcnt_r == '0)
    else $error("bit count not restarted");
  a_wake_on_select: assert property (pwr_r == ssst_pkg::SSST_SLEEP && cs_fall
    |=> pwr_r == ssst_pkg::SSST_WAKE && wake_cnt_r == WAKE_LAST)
    else $error("select did not start wake");
  a_wake_done: assert property (pwr_r == ssst_pkg::SSST_WAKE && wake_cnt_r == '0 |=> awake)
    else $error("wake recovery did not end");
  a_conv_spacing: assert property (conv_strobe
    |-> base_r == '0 && mult_r == '0 && $past(awake))
    else $error("conversion strobe out of place");
  a_conv_period: assert property (conv_strobe && steady_r
    |-> gap_r == conv_period - 32'h1)
    else $error("conversion period wrong for the setting");

  c_full_word: cover property (rx_valid);
  c_wake_up: cover property (pwr_r == ssst_pkg::SSST_WAKE ##1 awake);
  c_conversion: cover property (conv_strobe);
  c_queue_full: cover property (!tx_ready && cs_fall);
endmodule : ssst_spi_dev

// *** tb/ssst_host_model.sv ***
// ssst_host_model: mode 3 serial master standing in for the host controller.
// assumes the bench calls xfer or noise; dout counts as released while dout_oe is low.
`timescale 1ns/1ps
module ssst_host_model (
  // serial pins
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout_o,
  input wire logic dout_oe,
  // pacing and results
  input wire logic fast,
  output logic [15:0] got,
  output logic got_early,
  output logic got_stb
);
  logic last;
  logic dout_w;
  realtime t_start;
  realtime t_update;
  // a released line shows the inverse of its last driven value, never a stale copy
  always @(dout_o or dout_oe) if (dout_oe) last = dout_o;
  assign dout_w = dout_oe ? dout_o : ~last;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
    got = '0;
    got_early = 1'b0;
    got_stb = 1'b0;
    last = 1'b0;
    t_start = -1.0e6;
    // no memory update is ever asked for here, so the hold-off stays dormant
    t_update = -1.0e9;
  end
  task automatic xfer(input logic [15:0] w, input int n);
    while ($realtime < t_update + 50.0e6) #100;
    while ($realtime < t_start + (fast ? 32000.0 : 42000.0)) #100;
    t_start = $realtime;
    cs_n = 1'b0;
    #200;
    got_early = dout_w;
    for (int i = 15; i > 15 - n; i--) begin
      sclk = 1'b0;
      din = w[i];
      #80;
      sclk = 1'b1;
      got[i] = dout_w;
      #80;
    end
    #100;
    cs_n = 1'b1;
    din = ~din;
    if (n == 16) begin
      got_stb = 1'b1;
      #10 got_stb = 1'b0;
    end
    #(fast ? 9000 : 12000);
  endtask : xfer
  // clock and data wiggle with chip select high; breaks the idle rule on purpose
  task automatic noise();
    for (int i = 0; i < 8; i++) begin
      sclk = ~sclk;
      din = ~din;
      #80;
    end
  endtask : noise
endmodule : ssst_host_model

// *** tb/ssst_spi_dev_tb_top.sv ***
// ssst_spi_dev_tb_top: self-checking bench for the sensor serial slave.
// assumes shortened wake and conversion counts; the host model drives the pins.
`timescale 1ns/1ps
module ssst_spi_dev_tb_top;
  localparam int WAKE_N = 20;
  localparam int CONV_N = 4;
  logic mclk, rst, cs_n, sclk, din, dout_o, dout_oe, tx_valid, tx_ready, rx_valid;
  logic sleep_req, fast_mode, awake, conv_strobe, busy, got_early, got_stb, fast;
  logic [15:0] tx_data, rx_data, got, lfsr;
  logic [3:0] setting;
  logic [15:0] exp_rx[$];
  logic [15:0] exp_miso[$];
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;
  assign fast = (setting >= 4'h7);
  ssst_spi_dev #(.WAKE_CYC(WAKE_N), .CONV_CYC(CONV_N)) ssst_spi_dev_i (.mclk(mclk), .rst(rst),
    .cs_n(cs_n), .sclk(sclk), .din(din), .dout_o(dout_o), .dout_oe(dout_oe),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .sample_period_setting(setting), .sleep_req(sleep_req),
    .fast_mode(fast_mode), .awake(awake), .conv_strobe(conv_strobe), .busy(busy));
  ssst_host_model ssst_host_model_i (.cs_n(cs_n), .sclk(sclk), .din(din), .dout_o(dout_o),
    .dout_oe(dout_oe), .fast(fast), .got(got), .got_early(got_early), .got_stb(got_stb));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk_word(input logic [15:0] a, input logic [15:0] e, input string m);
    n_tests++;
    if (a !== e) begin
      mismatches++;
      $display("[FAIL] %0t %s: got %h want %h", $time, m, a, e);
    end
  endtask : chk_word
  task automatic chk_bit(input logic a, input logic e, input string m);
    chk_word({15'h0000, a}, {15'h0000, e}, m);
  endtask : chk_bit
  task automatic chk_num(input int a, input int e, input string m);
    chk_word(a[15:0], e[15:0], m);
  endtask : chk_num
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd
  task automatic push(input logic [15:0] w);
    exp_miso.push_back(w);
    @(posedge mclk);
    #1 tx_valid = 1'b1;
    tx_data = w;
    do @(posedge mclk); while (tx_ready !== 1'b1);
    #1 tx_valid = 1'b0;
  endtask : push
  task automatic frame(input logic [15:0] w, input int nb);
    if (nb == 16) exp_rx.push_back(w);
    ssst_host_model_i.xfer(w, nb);
  endtask : frame
  // skip to a settled schedule before measuring, a setting change may cut a period short
  task automatic conv_gap(input logic [3:0] s, input int e);
    @(posedge mclk);
    #1 setting = s;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge mclk);
        #1 n++;
      end while (conv_strobe !== 1'b1 && n < 20000);
    end
    chk_num(n, e, "conversion gap");
  endtask : conv_gap
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      finish_test();
    end
  end
  always @(posedge mclk) if (rx_valid === 1'b1) begin
    chk_bit(busy, 1'b1, "busy in frame");
    if (exp_rx.size() == 0) chk_bit(1'b1, 1'b0, "unexpected word");
    else chk_word(rx_data, exp_rx.pop_front(), "received word");
  end
  always @(posedge got_stb) begin
    if (exp_miso.size() == 0) chk_bit(1'b1, 1'b0, "unexpected reply");
    else begin
      chk_bit(got_early, exp_miso[0][15], "msb at select");
      chk_word(got, exp_miso.pop_front(), "sent word");
    end
  end
  initial begin
    rst = 1'b1;
    tx_valid = 1'b0;
    tx_data = 16'h0000;
    setting = 4'h1;
    sleep_req = 1'b0;
    lfsr = 16'h0e89;
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    chk_bit(dout_oe, 1'b0, "reset release");
    chk_bit(tx_ready, 1'b1, "reset ready");
    chk_bit(awake, 1'b1, "reset awake");
    for (int s = 6; s < 8; s++) begin
      @(posedge mclk);
      #1 setting = s[3:0];
      @(negedge mclk) chk_bit(fast_mode, s >= 7, "fast mode");
    end
    $display("test mode done");
    @(posedge mclk);
    #1 setting = 4'h8;
    for (int i = 0; i < 4; i++) push(rnd());
    chk_bit(tx_ready, 1'b0, "queue full");
    fork
      push(rnd());
      frame(rnd(), 16);
    join
    repeat (4) frame(rnd(), 16);
    chk_bit(dout_oe, 1'b0, "released after frame");
    chk_bit(busy, 1'b0, "idle after frame");
    $display("test queue done");
    setting = 4'h1;
    ssst_host_model_i.noise();
    frame(rnd(), 7);
    exp_miso.push_back(16'h0000);
    frame(rnd(), 16);
    $display("test partial done");
    @(posedge mclk);
    #1 sleep_req = 1'b1;
    @(posedge mclk);
    #1 sleep_req = 1'b0;
    @(posedge mclk);
    #1 chk_bit(awake, 1'b0, "asleep");
    exp_miso.push_back(16'h0000);
    fork
      frame(rnd(), 16);
      begin
        wait (cs_n === 1'b0);
        n = 0;
        while (awake !== 1'b1 && n < 100) begin
          @(posedge mclk);
          #1 n++;
        end
        chk_bit(n >= WAKE_N + 1 && n <= WAKE_N + 6, 1'b1, "wake time");
      end
    join
    $display("test wake done");
    conv_gap(4'h1, CONV_N);
    conv_gap(4'hf, CONV_N * 1984);
    $display("test conversion done");
    finish_test();
  end
endmodule : ssst_spi_dev_tb_top
